//--- tb_vpo_powerup_cfg.sv
// Self-checking testbench of the power-up option loader
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) \
    begin \
        comparisons++; \
        if ((a) !== (b)) \
        begin \
            errors++; \
            $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); \
        end \
    end
module tb_vpo_powerup_cfg;
    import vpo_pkg::*;
    localparam int unsigned AC = 20;
    logic clk = 1'b0;
    logic nrst, power_up_reset_in_n, backplane_sys_reset_in_n, syscon_enable_strap_n;
    logic syscon_disable_strap_n, grant3_daisy_in_n, board_fail_n, slot_id_fail_wr;
    logic slot_id_fail_wdata, board_fail_sw_wr, board_fail_sw_wdata, fail_enable_wr;
    logic fail_enable_wdata, fail_enable_set_bit, fail_enable_clear_bit, cfg_enable_wr;
    logic cfg_enable_wdata, cfg_base_wr, irq2_ack, transceiver_enable_n, system_fail_out;
    logic slot_id_fail_bit, fail_enable_bit, board_fail_sw_bit, board_fail_ind, cfg_space_attr;
    logic cfg_decode_zero, irq2_request, auto_slot_id_mode, cfg_error, system_controller_role;
    logic syscon_strap_err, straps_latched;
    logic [STRAP_W-1:0] strap_data, strap_pull, ack_wait;
    logic [GA_W-1:0] geo_addr_n, cfg_base_wdata, cfg_base_addr_bits, slot_base;
    int errors = 0;
    int comparisons = 0;
    vpo_powerup_cfg #(.AUTOCLR_CYCLES(AC)) dut (
        .clk, .nrst, .power_up_reset_in_n, .backplane_sys_reset_in_n, .strap_data, .geo_addr_n,
        .syscon_enable_strap_n, .syscon_disable_strap_n, .grant3_daisy_in_n, .board_fail_n,
        .slot_id_fail_wr, .slot_id_fail_wdata, .board_fail_sw_wr, .board_fail_sw_wdata,
        .fail_enable_wr, .fail_enable_wdata, .fail_enable_set_bit, .fail_enable_clear_bit,
        .cfg_enable_wr, .cfg_enable_wdata, .cfg_base_wr, .cfg_base_wdata, .irq2_ack,
        .transceiver_enable_n, .system_fail_out, .slot_id_fail_bit, .fail_enable_bit,
        .board_fail_sw_bit, .board_fail_ind, .cfg_space_attr, .cfg_base_addr_bits,
        .cfg_decode_zero, .irq2_request, .auto_slot_id_mode, .cfg_error, .system_controller_role,
        .syscon_strap_err, .straps_latched
    );
    vpo_backplane bp (
        .clk, .transceiver_enable_n, .irq2_request, .system_fail_out, .strap_pull, .slot_base,
        .ack_wait, .strap_data, .irq2_ack, .cfg_base_wr, .cfg_base_wdata
    );
    // Clock of 40 ns
    initial
        forever #20 clk = ~clk;
    // Move just past the next rising edges
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Power-up pulse; every option source is flipped once the straps are taken
    task automatic power_up(input logic [3:0] v, input logic [4:0] ga, input logic [2:0] r);
        power_up_reset_in_n = 1'b0;
        strap_pull = v;
        geo_addr_n = ga;
        {grant3_daisy_in_n, syscon_disable_strap_n, syscon_enable_strap_n} = r;
        tick(2);
        `CHK({transceiver_enable_n, straps_latched}, 2'h2)
        power_up_reset_in_n = 1'b1;
        tick(1);
        `CHK(transceiver_enable_n, 1'b0)
        geo_addr_n = ~ga;
        {grant3_daisy_in_n, syscon_disable_strap_n, syscon_enable_strap_n} = ~r;
        tick(3);
    endtask
    // Hold the backplane system reset for n cycles
    task automatic sys_reset(input int n);
        backplane_sys_reset_in_n = 1'b0;
        tick(n);
        backplane_sys_reset_in_n = 1'b1;
    endtask
    // Every strap value, geographic pins high and not, role straps cycled alongside
    task automatic mode_table();
        logic [3:0] v;
        logic [4:0] ga;
        logic ill, aut;
        for (int i = 0; i < 32; i++)
        begin
            v = i[3:0];
            ga = i[4] ? GA_ALL_HIGH : 5'h0a;
            ill = v[2] & v[0];
            aut = !ill && v[2] && (!v[3] || i[4]);
            power_up(v, ga, i[2:0]);
            `CHK(system_controller_role, i[0] ? i[1] & !i[2] : i[1])
            `CHK(syscon_strap_err, !i[0] & !i[1])
            backplane_sys_reset_in_n = 1'b0;
            tick(2);
            `CHK({cfg_error, auto_slot_id_mode}, {ill, aut})
            `CHK(cfg_space_attr, !ill && v[3] && !aut)
            `CHK({slot_id_fail_bit, fail_enable_bit}, {aut, v[0] & !ill})
            if (!ill)
                `CHK(cfg_base_addr_bits, v[3] ? ~ga : 5'h00)
            backplane_sys_reset_in_n = 1'b1;
            tick(2);
        end
    endtask
    // Auto slot ID with timed clear, slow monarch assigning the base
    task automatic auto_clear_flow();
        int n;
        ack_wait = 4'h3;
        power_up(4'h6, 5'h0a, 3'h2);
        sys_reset(3);
        n = 0;
        while (slot_id_fail_bit === 1'b1 && n < 200)
        begin
            tick(1);
            n++;
            if (n == 2)
                `CHK({irq2_request, system_fail_out}, 2'h3)
        end
        `CHK(n, AC + 2)
        `CHK(cfg_decode_zero, 1'b1)
        tick(1);
        `CHK(system_fail_out, 1'b0)
        tick(10);
        `CHK({irq2_request, cfg_decode_zero, cfg_base_addr_bits}, {2'h0, slot_base})
    endtask
    // Auto slot ID without timed clear: software clears, prompt monarch, software sets
    task automatic soft_clear_flow();
        ack_wait = 4'h0;
        power_up(4'h4, 5'h0a, 3'h2);
        sys_reset(2);
        tick(AC + 10);
        `CHK({slot_id_fail_bit, system_fail_out, irq2_request}, 3'h7)
        slot_id_fail_wdata = 1'b0;
        slot_id_fail_wr = 1'b1;
        tick(1);
        slot_id_fail_wr = 1'b0;
        `CHK(slot_id_fail_bit, 1'b0)
        tick(1);
        `CHK(system_fail_out, 1'b0)
        tick(4);
        `CHK({irq2_request, cfg_base_addr_bits}, {1'b0, slot_base})
        slot_id_fail_wdata = 1'b1;
        slot_id_fail_wr = 1'b1;
        tick(1);
        slot_id_fail_wr = 1'b0;
        tick(1);
        `CHK({slot_id_fail_bit, system_fail_out}, 2'h3)
    endtask
    // Fail enable views and both board fail sources in geographic mode
    task automatic fail_views();
        power_up(4'h8, 5'h0a, 3'h1);
        sys_reset(2);
        board_fail_n = 1'b0;
        tick(4);
        `CHK({board_fail_ind, fail_enable_bit, system_fail_out}, 3'h4)
        fail_enable_set_bit = 1'b1;
        tick(1);
        fail_enable_set_bit = 1'b0;
        `CHK(fail_enable_bit, 1'b1)
        tick(1);
        `CHK(system_fail_out, 1'b1)
        fail_enable_clear_bit = 1'b1;
        tick(1);
        fail_enable_clear_bit = 1'b0;
        tick(1);
        `CHK({fail_enable_bit, system_fail_out}, 2'h0)
        fail_enable_wdata = 1'b1;
        fail_enable_wr = 1'b1;
        tick(1);
        fail_enable_wr = 1'b0;
        board_fail_n = 1'b1;
        tick(4);
        `CHK({fail_enable_bit, board_fail_ind, system_fail_out}, 3'h4)
        board_fail_sw_wdata = 1'b1;
        board_fail_sw_wr = 1'b1;
        tick(1);
        board_fail_sw_wr = 1'b0;
        tick(2);
        `CHK({board_fail_sw_bit, board_fail_ind, system_fail_out}, 3'h7)
        cfg_enable_wdata = 1'b0;
        cfg_enable_wr = 1'b1;
        tick(1);
        cfg_enable_wr = 1'b0;
        `CHK(cfg_space_attr, 1'b0)
        sys_reset(2);
        `CHK({cfg_space_attr, cfg_base_addr_bits, board_fail_sw_bit}, 7'h6a)
    endtask
    // Print the counts and the verdict, then stop
    task automatic complete_run();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Watchdog well beyond the expected run of about 18 us
    initial
    begin
        #400000;
        errors++;
        complete_run();
    end
    // Main sequence
    initial
    begin
        {nrst, power_up_reset_in_n, slot_id_fail_wr, slot_id_fail_wdata, board_fail_sw_wr,
         board_fail_sw_wdata, fail_enable_wr, fail_enable_wdata, fail_enable_set_bit,
         fail_enable_clear_bit, cfg_enable_wr, cfg_enable_wdata} = '0;
        {backplane_sys_reset_in_n, syscon_enable_strap_n, syscon_disable_strap_n,
         grant3_daisy_in_n, board_fail_n} = '1;
        strap_pull = 4'h0;
        ack_wait = 4'h0;
        geo_addr_n = 5'h0a;
        slot_base = 5'h13;
        tick(16);
        nrst = 1'b1;
        tick(4);
        mode_table();
        auto_clear_flow();
        soft_clear_flow();
        fail_views();
        complete_run();
    end
endmodule
`default_nettype wire

//--- vpo_backplane.sv
// Backplane model: strap pulls, data bus traffic and the slot-ID monarch
`timescale 1ns/100ps
`default_nettype none
module vpo_backplane (
    input wire logic clk, // Clock
    input wire logic transceiver_enable_n, // Board transceivers off when high
    input wire logic irq2_request, // Level-two request from the board
    input wire logic system_fail_out, // Board system fail drive
    input wire logic [3:0] strap_pull, // Pull resistor levels
    input wire logic [4:0] slot_base, // Base the monarch assigns
    input wire logic [3:0] ack_wait, // Monarch response delay
    output logic [3:0] strap_data, // Data lines 3..0 at the board
    output var logic irq2_ack = 1'b0, // Acknowledge pulse
    output var logic cfg_base_wr = 1'b0, // Base write strobe
    output logic [4:0] cfg_base_wdata // Base write value
);
    logic [3:0] bus_pat = 4'h0;
    logic [3:0] cnt = 4'h0;
    // Pulls only win while the transceivers are off; other traffic is seen otherwise
    assign strap_data = transceiver_enable_n ? strap_pull : bus_pat;
    assign cfg_base_wdata = slot_base;
    // Bus traffic pattern holds the inverted pulls while off, then changes every cycle so a resample shows up
    always @(posedge clk)
        bus_pat <= transceiver_enable_n ? ~strap_pull : ~bus_pat;
    // Monarch waits for system fail to drop, acknowledges, then writes the base
    always @(posedge clk)
    begin
        irq2_ack <= 1'b0;
        cfg_base_wr <= irq2_ack;
        cnt <= 4'h0;
        if (irq2_request && !system_fail_out && !irq2_ack && !cfg_base_wr)
        begin
            cnt <= cnt + 4'h1;
            irq2_ack <= (cnt == ack_wait);
        end
    end
endmodule
`default_nettype wire

//--- vpo_fail_timer.sv
// One-shot delay timer for the slot-ID fail auto clear
`timescale 1ns/100ps
`default_nettype none
module vpo_fail_timer #(
    parameter int unsigned CYCLES = vpo_pkg::AUTOCLR_CYCLES
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Synchronised reset, active low
    vpo_tmr_if.timer tmr // Start, cancel and done
);
    import vpo_pkg::*;

    localparam int unsigned CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] count_reg;
    logic run_reg;
    logic done_reg;

    // Count from start; done pulses CYCLES cycles after start
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_reg <= '0;
            run_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else if (tmr.cancel)
        begin
            count_reg <= '0;
            run_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else if (tmr.start)
        begin
            count_reg <= '0;
            run_reg <= 1'b1;
            done_reg <= 1'b0;
        end
        else if (run_reg && count_reg == LAST)
        begin
            run_reg <= 1'b0;
            done_reg <= 1'b1;
        end
        else
        begin
            count_reg <= run_reg ? count_reg + 1'b1 : count_reg;
            done_reg <= 1'b0;
        end
    end

    assign tmr.done = done_reg;
    assign tmr.busy = run_reg;
endmodule
`default_nettype wire

//--- vpo_pkg.sv
// Shared constants and types for the power-up option loader
`default_nettype none
package vpo_pkg;
    // Strap positions on the data lines
    localparam int unsigned STRAP_W = 4;
    localparam int unsigned STRAP_FAIL_EN = 0;
    localparam int unsigned STRAP_AUTOCLR = 1;
    localparam int unsigned STRAP_ASID = 2;
    localparam int unsigned STRAP_GSID = 3;
    // Geographic address and base address widths
    localparam int unsigned GA_W = 5;
    // Reset values of control state
    localparam logic [STRAP_W-1:0] STRAP_RST = 4'h0;
    localparam logic [GA_W-1:0] BASE_RST = 5'h00;
    localparam logic [GA_W-1:0] GA_ALL_HIGH = 5'h1f;
    // Auto clear delay of the slot-ID fail bit
    localparam int unsigned AUTOCLR_TIME_US = 1000;
    localparam int unsigned CLK_FREQ_MHZ = 25;
    localparam int unsigned AUTOCLR_CYCLES = AUTOCLR_TIME_US * CLK_FREQ_MHZ;
    // Base address assignment method
    typedef enum logic [1:0] {
        VPO_MODE_DISABLED,
        VPO_MODE_GEO,
        VPO_MODE_AUTO,
        VPO_MODE_ILLEGAL
    } vpo_mode_e;
endpackage
`default_nettype wire

//--- vpo_powerup_cfg.sv
// Backplane power-up option loader, fail logic and system controller select
`timescale 1ns/100ps
`default_nettype none
module vpo_powerup_cfg #(
    parameter int unsigned AUTOCLR_CYCLES = vpo_pkg::AUTOCLR_CYCLES
) (
    input wire logic clk, // 25 MHz system clock
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic power_up_reset_in_n, // Power-up reset, active low
    input wire logic backplane_sys_reset_in_n, // Backplane system reset, active low
    input wire logic [vpo_pkg::STRAP_W-1:0] strap_data, // Data lines 3..0
    input wire logic [vpo_pkg::GA_W-1:0] geo_addr_n, // Geographic address pins
    input wire logic syscon_enable_strap_n, // Role enable strap
    input wire logic syscon_disable_strap_n, // Role disable strap
    input wire logic grant3_daisy_in_n, // Bus grant 3 daisy input
    input wire logic board_fail_n, // External board fail, active low
    input wire logic slot_id_fail_wr, // Write strobe slot fail bit
    input wire logic slot_id_fail_wdata, // Value for slot fail bit
    input wire logic board_fail_sw_wr, // Write strobe board fail bit
    input wire logic board_fail_sw_wdata, // Value for board fail bit
    input wire logic fail_enable_wr, // Write strobe fail enable bit
    input wire logic fail_enable_wdata, // Value for fail enable bit
    input wire logic fail_enable_set_bit, // Pulse, sets fail enable
    input wire logic fail_enable_clear_bit, // Pulse, clears fail enable
    input wire logic cfg_enable_wr, // Write strobe space enable
    input wire logic cfg_enable_wdata, // Value for space enable
    input wire logic cfg_base_wr, // Write strobe base bits
    input wire logic [vpo_pkg::GA_W-1:0] cfg_base_wdata, // Value for base bits
    input wire logic irq2_ack, // Pulse, level-two request acknowledged
    output logic transceiver_enable_n, // Data transceiver enable, active low
    output logic system_fail_out, // System fail drive
    output logic slot_id_fail_bit, // Slot-ID fail state
    output logic fail_enable_bit, // Fail enable state
    output logic board_fail_sw_bit, // Software board fail state
    output logic board_fail_ind, // Board fail indication
    output logic cfg_space_attr, // Configuration space enable
    output logic [vpo_pkg::GA_W-1:0] cfg_base_addr_bits, // Base address bits 7..3
    output logic cfg_decode_zero, // Decode configuration space at zero
    output logic irq2_request, // Level-two interrupt request
    output logic auto_slot_id_mode, // Auto slot ID selected
    output logic cfg_error, // Illegal strap combination
    output logic system_controller_role, // Role enabled
    output logic syscon_strap_err, // Both role straps low
    output logic straps_latched // Straps captured
);
    import vpo_pkg::*;

    // Method chosen from straps and geographic pins
    function automatic vpo_mode_e decode_mode(input logic [STRAP_W-1:0] s,
                                              input logic ga_high);
        vpo_mode_e m;
        m = VPO_MODE_DISABLED;
        case ({s[STRAP_GSID], s[STRAP_ASID]})
            2'b00: m = VPO_MODE_DISABLED;
            2'b01: m = s[STRAP_FAIL_EN] ? VPO_MODE_ILLEGAL : VPO_MODE_AUTO;
            2'b10: m = VPO_MODE_GEO;
            2'b11:
            begin
                if (s[STRAP_FAIL_EN])
                    m = VPO_MODE_ILLEGAL;
                else
                    m = ga_high ? VPO_MODE_AUTO : VPO_MODE_GEO;
            end
            default: m = VPO_MODE_DISABLED;
        endcase
        return m;
    endfunction

    logic rst_meta_reg;
    logic rst_n;
    logic pur_prev_reg;
    logic srst_prev_reg;
    logic latch_pulse_reg;
    logic [STRAP_W-1:0] straps_reg;
    logic [GA_W-1:0] ga_reg;
    vpo_mode_e mode_reg;
    logic base_programmed_reg;
    logic pur_rise;
    logic srst_active;
    logic srst_release;
    logic apply_defaults;
    logic reset_done;
    logic is_auto;
    logic slot_fail_default;
    logic fail_en_default;
    logic cfg_en_default;
    logic [GA_W-1:0] base_default;
    vpo_tmr_if tmr ();

    // Reset release through two flip-flops
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // Edge history of both reset inputs
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pur_prev_reg <= 1'b0;
            srst_prev_reg <= 1'b0;
            latch_pulse_reg <= 1'b0;
        end
        else
        begin
            pur_prev_reg <= power_up_reset_in_n;
            srst_prev_reg <= backplane_sys_reset_in_n;
            latch_pulse_reg <= pur_rise;
        end
    end

    assign pur_rise = power_up_reset_in_n & ~pur_prev_reg;
    assign srst_active = ~backplane_sys_reset_in_n & straps_latched;
    assign srst_release = backplane_sys_reset_in_n & ~srst_prev_reg & straps_latched;
    // Defaults applied after the latch and while system reset is held
    assign apply_defaults = latch_pulse_reg | srst_active;
    // End of a reset, the point the auto slot ID sequence starts from
    assign reset_done = latch_pulse_reg | srst_release;

    // Strap capture on the power-up reset rising edge only
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            straps_reg <= STRAP_RST;
            ga_reg <= GA_ALL_HIGH;
            mode_reg <= VPO_MODE_DISABLED;
            straps_latched <= 1'b0;
        end
        else if (!power_up_reset_in_n)
        begin
            straps_latched <= 1'b0;
        end
        else if (pur_rise && !straps_latched)
        begin
            straps_reg <= strap_data;
            ga_reg <= geo_addr_n;
            mode_reg <= decode_mode(strap_data, geo_addr_n == GA_ALL_HIGH);
            straps_latched <= 1'b1;
        end
    end

    // Transceivers off while power-up reset holds the straps
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            transceiver_enable_n <= 1'b1;
        else
            transceiver_enable_n <= ~(power_up_reset_in_n & (straps_latched | pur_rise));
    end

    // System controller role decode
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            system_controller_role <= 1'b0;
            syscon_strap_err <= 1'b0;
        end
        else if (pur_rise && !straps_latched)
        begin
            case ({syscon_enable_strap_n, syscon_disable_strap_n})
                2'b01: system_controller_role <= 1'b1;
                2'b10: system_controller_role <= 1'b0;
                2'b11: system_controller_role <= ~grant3_daisy_in_n;
                default: system_controller_role <= 1'b0;
            endcase
            syscon_strap_err <= ~syscon_enable_strap_n & ~syscon_disable_strap_n;
        end
    end

    // Default values implied by the latched method
    assign is_auto = (mode_reg == VPO_MODE_AUTO);
    assign slot_fail_default = is_auto;
    assign fail_en_default = straps_reg[STRAP_FAIL_EN] &
                             (mode_reg == VPO_MODE_DISABLED || mode_reg == VPO_MODE_GEO);
    assign cfg_en_default = straps_reg[STRAP_GSID] & (mode_reg == VPO_MODE_GEO);
    assign base_default = straps_reg[STRAP_GSID] ? ~ga_reg : BASE_RST;

    // Configuration space enable and base bits
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_space_attr <= 1'b0;
            cfg_base_addr_bits <= BASE_RST;
            base_programmed_reg <= 1'b0;
        end
        else if (apply_defaults)
        begin
            cfg_space_attr <= cfg_en_default;
            cfg_base_addr_bits <= base_default;
            base_programmed_reg <= 1'b0;
        end
        else
        begin
            if (cfg_enable_wr)
                cfg_space_attr <= cfg_enable_wdata;
            if (cfg_base_wr)
            begin
                cfg_base_addr_bits <= cfg_base_wdata;
                base_programmed_reg <= 1'b1;
            end
        end
    end

    // Auto clear timer runs from the end of reset in auto clear modes
    assign tmr.start = reset_done & is_auto & straps_reg[STRAP_AUTOCLR];
    assign tmr.cancel = srst_active | slot_id_fail_wr;

    vpo_fail_timer #(
        .CYCLES(AUTOCLR_CYCLES)
    ) u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .tmr(tmr)
    );

    // Slot-ID fail bit; the reset set wins over any clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            slot_id_fail_bit <= 1'b0;
        else if (apply_defaults)
            slot_id_fail_bit <= slot_fail_default;
        else if (slot_id_fail_wr)
            slot_id_fail_bit <= slot_id_fail_wdata;
        else if (tmr.done)
            slot_id_fail_bit <= 1'b0;
    end

    // Fail enable, one state behind three views; set beats clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            fail_enable_bit <= 1'b0;
        else if (apply_defaults)
            fail_enable_bit <= fail_en_default;
        else if (fail_enable_set_bit)
            fail_enable_bit <= 1'b1;
        else if (fail_enable_clear_bit)
            fail_enable_bit <= 1'b0;
        else if (fail_enable_wr)
            fail_enable_bit <= fail_enable_wdata;
    end

    // Software board fail bit, cleared by reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            board_fail_sw_bit <= 1'b0;
        else if (apply_defaults)
            board_fail_sw_bit <= 1'b0;
        else if (board_fail_sw_wr)
            board_fail_sw_bit <= board_fail_sw_wdata;
    end

    // Board fail indication and system fail drive
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            board_fail_ind <= 1'b0;
            system_fail_out <= 1'b0;
        end
        else
        begin
            board_fail_ind <= board_fail_sw_bit | ~board_fail_n;
            system_fail_out <= slot_id_fail_bit |
                               (fail_enable_bit & board_fail_ind);
        end
    end

    // Level-two request after reset; a new reset wins over acknowledge
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            irq2_request <= 1'b0;
        else if (srst_active)
            irq2_request <= 1'b0;
        else if (reset_done && is_auto)
            irq2_request <= 1'b1;
        else if (irq2_ack || cfg_base_wr)
            irq2_request <= 1'b0;
    end

    // Mode status and zero-address decode before the base is assigned
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            auto_slot_id_mode <= 1'b0;
            cfg_error <= 1'b0;
            cfg_decode_zero <= 1'b0;
        end
        else
        begin
            auto_slot_id_mode <= straps_latched & is_auto;
            cfg_error <= straps_latched & (mode_reg == VPO_MODE_ILLEGAL);
            cfg_decode_zero <= straps_latched & is_auto &
                               (apply_defaults | ~base_programmed_reg);
        end
    end
endmodule
`default_nettype wire

//--- vpo_powerup_cfg_asserts.sv
// Concurrent checks on the power-up option loader ports
`timescale 1ns/100ps
`default_nettype none
module vpo_powerup_cfg_asserts #(
    parameter int unsigned AUTOCLR_CYCLES = vpo_pkg::AUTOCLR_CYCLES
) (
    input wire logic clk, // Clock
    input wire logic nrst, // Reset
    input wire logic power_up_reset_in_n, // Power-up reset
    input wire logic backplane_sys_reset_in_n, // System reset
    input wire logic syscon_enable_strap_n, // Role enable strap
    input wire logic syscon_disable_strap_n, // Role disable strap
    input wire logic grant3_daisy_in_n, // Grant-3 input
    input wire logic board_fail_n, // External board fail
    input wire logic transceiver_enable_n, // Transceiver enable
    input wire logic system_fail_out, // System fail
    input wire logic slot_id_fail_bit, // Slot fail
    input wire logic fail_enable_bit, // Fail enable
    input wire logic board_fail_ind, // Board fail
    input wire logic cfg_space_attr, // Space enable
    input wire logic cfg_decode_zero, // Decode at zero
    input wire logic irq2_request, // Level-two request
    input wire logic auto_slot_id_mode, // Auto mode
    input wire logic cfg_error, // Illegal straps
    input wire logic system_controller_role, // Role
    input wire logic straps_latched // Straps captured
);
    import vpo_pkg::*;
    logic role_exp;
    // Role expected from the straps and the grant-3 input
    assign role_exp = syscon_enable_strap_n ? syscon_disable_strap_n & !grant3_daisy_in_n
                                            : syscon_disable_strap_n;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    xcvr_off_a: assert property (!power_up_reset_in_n |=> transceiver_enable_n && !straps_latched)
        else $error("transceiver on during power-up reset");
    latch_on_a: assert property ($rose(power_up_reset_in_n) |=> straps_latched && !transceiver_enable_n)
        else $error("straps not taken at power-up release");
    role_a: assert property ($rose(power_up_reset_in_n) |=> system_controller_role == $past(role_exp))
        else $error("controller role wrongly decoded");
    straps_hold_a: assert property (straps_latched [*5] |-> $stable(cfg_error) && $stable(auto_slot_id_mode) && $stable(system_controller_role))
        else $error("latched options changed");
    auto_dflt_a: assert property (!backplane_sys_reset_in_n && straps_latched && auto_slot_id_mode |=> slot_id_fail_bit && !cfg_space_attr && !fail_enable_bit && !irq2_request && cfg_decode_zero)
        else $error("auto slot defaults wrong in system reset");
    err_dflt_a: assert property (!backplane_sys_reset_in_n && straps_latched && cfg_error |=> !cfg_space_attr && !slot_id_fail_bit && !fail_enable_bit)
        else $error("illegal straps not kept disabled");
    irq_rel_a: assert property (auto_slot_id_mode && $rose(backplane_sys_reset_in_n) |=> irq2_request)
        else $error("no level-two request after system reset");
    sysfail_on_a: assert property (slot_id_fail_bit && power_up_reset_in_n |=> system_fail_out)
        else $error("system fail not held with slot fail set");
    sysfail_off_a: assert property (!slot_id_fail_bit && !(fail_enable_bit && board_fail_ind) |=> !system_fail_out)
        else $error("system fail driven without cause");
    board_fail_a: assert property (!board_fail_n && straps_latched |-> ##[1:4] board_fail_ind)
        else $error("external board fail not indicated");
endmodule
bind vpo_powerup_cfg vpo_powerup_cfg_asserts #(.AUTOCLR_CYCLES(AUTOCLR_CYCLES)) u_asserts (
    .clk, .nrst, .power_up_reset_in_n, .backplane_sys_reset_in_n, .syscon_enable_strap_n,
    .syscon_disable_strap_n, .grant3_daisy_in_n, .board_fail_n, .transceiver_enable_n,
    .system_fail_out, .slot_id_fail_bit, .fail_enable_bit, .board_fail_ind, .cfg_space_attr,
    .cfg_decode_zero, .irq2_request, .auto_slot_id_mode, .cfg_error, .system_controller_role,
    .straps_latched
);
`default_nettype wire

//--- vpo_tmr_if.sv
// Carrier between the loader and its auto clear timer
`timescale 1ns/100ps
`default_nettype none
interface vpo_tmr_if;
    logic start;
    logic cancel;
    logic done;
    logic busy;
    modport ctrl (output start, output cancel, input done, input busy);
    modport timer (input start, input cancel, output done, output busy);
endinterface
`default_nettype wire
